// *** design/plc_pkg.sv ***
// Shared offsets, field positions, reset values and encodings of the port lookup/PTP bank
package plc_pkg;
   // ==========================================================
   // Register offsets within one port space (port number is the top hex digit)
   localparam logic [11:0] OFF_LOOKUP_CTRL = 12'h0b00;
   localparam logic [11:0] OFF_INST_PTR = 12'h0b01;
   localparam logic [11:0] OFF_INST_STATE = 12'h0b04;
   localparam logic [11:0] OFF_RX_LAT = 12'h0c00;
   localparam logic [11:0] OFF_TX_LAT = 12'h0c02;
   localparam logic [11:0] OFF_SKEW = 12'h0c04;
   // ==========================================================
   // Field positions
   localparam int BIT_NULL_VID = 7;
   localparam int BIT_INGRESS_FILT = 6;
   localparam int BIT_DISCARD_NONDEF = 5;
   localparam int BIT_MAC_8021X = 4;
   localparam int BIT_SELF_FILT = 3;
   localparam int BIT_TX_EN = 2;
   localparam int BIT_RX_EN = 1;
   localparam int BIT_LEARN_DIS = 0;
   localparam int BIT_SKEW_SIGN = 15;
   localparam logic [7:0] CTRL_WR_MASK = 8'hfa;
   localparam logic [7:0] STATE_WR_MASK = 8'h07;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_LOOKUP_CTRL = 8'h00;
   localparam logic [7:0] RST_INST_PTR = 8'h00;
   localparam logic [2:0] RST_INST_STATE = 3'h6;
   localparam logic [15:0] RST_RX_LAT = 16'h019f;
   localparam logic [15:0] RST_TX_LAT = 16'h002d;
   localparam logic [15:0] RST_SKEW = 16'h0000;
   // ==========================================================
   // Message types seen by the correction path
   typedef enum logic [3:0] {
      PLC_MSG_SYNC = 4'h0,
      PLC_MSG_DELAY_REQ = 4'h1,
      PLC_MSG_PDELAY_REQ = 4'h2,
      PLC_MSG_PDELAY_RESP = 4'h3
   } plc_msg_e;
endpackage : plc_pkg

// *** design/plc_port_bank.sv ***
// Per-port lookup and PTP configuration bank with frame decision and timing correction
`timescale 1ns/1ps

// Behaviour
// - Null-VID bit picks VID zero or default
// - Ingress filtering drops frames without port membership
// - Drop frames whose VID differs from default
// - MAC based 802.1X enable drives lookup engine
// - Drop frames whose source equals switch MAC
// - Self filtering needs port and global enable
// - Pointer selects one of eight instance entries
// - Transmit enable per instance, resets to one
// - Receive enable per instance, resets to one
// - Learning disable per instance, resets to zero
// - Receive latency 16-bit ns, reset 415
// - Transmit latency 16-bit ns, reset 45
// - Top skew bit is sign of magnitude
// - Add skew to ingress Sync and Pdelay_Resp
// - Subtract skew from egress Delay_Req, Pdelay_Req
module plc_port_bank
   import plc_pkg::*;
#(
   parameter logic [3:0] PORT_NUM = 4'h1,
   parameter int VID_W = 12,
   parameter int INST_N = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Management register port, byte wide
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rdata_valid,
   // Received frame attributes
   input wire logic rx_valid,
   input wire logic rx_tagged,
   input wire logic [VID_W-1:0] rx_vid,
   input wire logic [VID_W-1:0] port_default_vlan,
   input wire logic rx_vlan_member,
   input wire logic [2:0] rx_instance,
   input wire logic [47:0] rx_src_mac,
   input wire logic [47:0] switch_mac,
   input wire logic self_filter_global_en,
   // Frame decision, one cycle after rx_valid
   output logic dec_valid,
   output logic [VID_W-1:0] dec_lookup_vid,
   output logic dec_drop,
   output logic dec_learn,
   // Static controls toward the lookup engine
   output logic mac_8021x_en,
   output logic [INST_N-1:0] tx_enable_map,
   output logic [INST_N-1:0] rx_enable_map,
   output logic [INST_N-1:0] learn_disable_map,
   // Timestamp adjustment
   input wire logic rx_ts_valid,
   input wire logic [31:0] rx_ts_raw,
   input wire logic tx_ts_valid,
   input wire logic [31:0] tx_ts_raw,
   output logic rx_ts_out_valid,
   output logic [31:0] rx_ts_wire,
   output logic tx_ts_out_valid,
   output logic [31:0] tx_ts_wire,
   // Correction field path, units of 2^-16 ns
   input wire logic corr_valid,
   input wire logic corr_egress,
   input wire logic [3:0] corr_msg_type,
   input wire logic [63:0] corr_in,
   output logic corr_out_valid,
   output logic [63:0] corr_out
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] ptr;
      logic [INST_N-1:0][2:0] inst;
      logic [15:0] rx_lat;
      logic [15:0] tx_lat;
      logic [15:0] skew;
      logic [7:0] rdata;
      logic rvalid;
      logic dvalid;
      logic [VID_W-1:0] dvid;
      logic ddrop;
      logic dlearn;
      logic rts_v;
      logic [31:0] rts;
      logic tts_v;
      logic [31:0] tts;
      logic cv;
      logic [63:0] corr;
   } plc_state_s;

   plc_state_s s;
   plc_state_s next_s;
   logic port_hit;
   logic [11:0] off;
   logic [VID_W-1:0] eff_vid;
   logic self_drop;
   logic [63:0] skew_scaled;
   logic [2:0] sel;

   assign port_hit = (reg_addr[15:12] == PORT_NUM);
   assign off = reg_addr[11:0];
   assign sel = s.ptr[2:0];

   // Signed skew in correction-field units; sign bit negates the magnitude
   always_comb begin
      skew_scaled = {33'h0_0000_0000, s.skew[14:0], 16'h0000};
      if (s.skew[BIT_SKEW_SIGN]) begin
         skew_scaled = 64'h0 - skew_scaled;
      end
   end

   // Null VID either stays zero or falls back to the port default
   always_comb begin
      eff_vid = rx_vid;
      if (!rx_tagged) begin
         eff_vid = port_default_vlan;
      end else if (rx_vid == '0 && !s.ctrl[BIT_NULL_VID]) begin
         eff_vid = port_default_vlan;
      end
   end

   assign self_drop = s.ctrl[BIT_SELF_FILT] && self_filter_global_en
      && (rx_src_mac == switch_mac);

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.rvalid = 1'b0;
      next_s.dvalid = rx_valid;
      next_s.rts_v = rx_ts_valid;
      next_s.tts_v = tx_ts_valid;
      next_s.cv = corr_valid;
      // Register writes; reserved read-only bits are masked off
      if (reg_wr && port_hit) begin
         case (off)
            OFF_LOOKUP_CTRL: next_s.ctrl = reg_wdata & CTRL_WR_MASK;
            OFF_INST_PTR: next_s.ptr = reg_wdata;
            OFF_INST_STATE: next_s.inst[sel] = reg_wdata[2:0] & STATE_WR_MASK[2:0];
            OFF_RX_LAT: next_s.rx_lat[15:8] = reg_wdata;
            OFF_RX_LAT + 12'h001: next_s.rx_lat[7:0] = reg_wdata;
            OFF_TX_LAT: next_s.tx_lat[15:8] = reg_wdata;
            OFF_TX_LAT + 12'h001: next_s.tx_lat[7:0] = reg_wdata;
            OFF_SKEW: next_s.skew[15:8] = reg_wdata;
            OFF_SKEW + 12'h001: next_s.skew[7:0] = reg_wdata;
            default: next_s.rdata = s.rdata;
         endcase
      end
      // Reads answer one cycle later; unmapped bytes read zero
      if (reg_rd) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = 8'h00;
         if (port_hit) begin
            case (off)
               OFF_LOOKUP_CTRL: next_s.rdata = s.ctrl;
               OFF_INST_PTR: next_s.rdata = s.ptr;
               OFF_INST_STATE: next_s.rdata = {5'h00, s.inst[sel]};
               OFF_RX_LAT: next_s.rdata = s.rx_lat[15:8];
               OFF_RX_LAT + 12'h001: next_s.rdata = s.rx_lat[7:0];
               OFF_TX_LAT: next_s.rdata = s.tx_lat[15:8];
               OFF_TX_LAT + 12'h001: next_s.rdata = s.tx_lat[7:0];
               OFF_SKEW: next_s.rdata = s.skew[15:8];
               OFF_SKEW + 12'h001: next_s.rdata = s.skew[7:0];
               default: next_s.rdata = 8'h00;
            endcase
         end
      end
      // Frame decision; any enabled discard condition is enough
      if (rx_valid) begin
         next_s.dvid = eff_vid;
         next_s.ddrop = (s.ctrl[BIT_INGRESS_FILT] && !rx_vlan_member)
            || (s.ctrl[BIT_DISCARD_NONDEF] && eff_vid != port_default_vlan)
            || self_drop
            || !s.inst[rx_instance][BIT_RX_EN];
         next_s.dlearn = !s.inst[rx_instance][BIT_LEARN_DIS];
      end
      // Wire time is the reference point moved back or forward by the latency
      if (rx_ts_valid) begin
         next_s.rts = rx_ts_raw - {16'h0000, s.rx_lat};
      end
      if (tx_ts_valid) begin
         next_s.tts = tx_ts_raw + {16'h0000, s.tx_lat};
      end
      if (corr_valid) begin
         next_s.corr = corr_in;
         if (!corr_egress && (corr_msg_type == PLC_MSG_SYNC
               || corr_msg_type == PLC_MSG_PDELAY_RESP)) begin
            next_s.corr = corr_in + skew_scaled;
         end else if (corr_egress && (corr_msg_type == PLC_MSG_DELAY_REQ
               || corr_msg_type == PLC_MSG_PDELAY_REQ)) begin
            next_s.corr = corr_in - skew_scaled;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s <= '0;
         s.ctrl <= RST_LOOKUP_CTRL;
         s.ptr <= RST_INST_PTR;
         s.inst <= {INST_N{RST_INST_STATE}};
         s.rx_lat <= RST_RX_LAT;
         s.tx_lat <= RST_TX_LAT;
         s.skew <= RST_SKEW;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   genvar gi;
   generate
      for (gi = 0; gi < INST_N; gi++) begin : g_inst
         assign tx_enable_map[gi] = s.inst[gi][BIT_TX_EN];
         assign rx_enable_map[gi] = s.inst[gi][BIT_RX_EN];
         assign learn_disable_map[gi] = s.inst[gi][BIT_LEARN_DIS];
      end
   endgenerate

   assign mac_8021x_en = s.ctrl[BIT_MAC_8021X];
   assign reg_rdata = s.rdata;
   assign reg_rdata_valid = s.rvalid;
   assign dec_valid = s.dvalid;
   assign dec_lookup_vid = s.dvid;
   assign dec_drop = s.ddrop;
   assign dec_learn = s.dlearn;
   assign rx_ts_out_valid = s.rts_v;
   assign rx_ts_wire = s.rts;
   assign tx_ts_out_valid = s.tts_v;
   assign tx_ts_wire = s.tts;
   assign corr_out_valid = s.cv;
   assign corr_out = s.corr;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_null_vid_zero: assert property (
      rx_valid && rx_tagged && rx_vid == '0 && s.ctrl[BIT_NULL_VID] |=> dec_lookup_vid == '0)
      else $error("null VID lookup not zero");
   a_null_vid_default: assert property (
      rx_valid && rx_tagged && rx_vid == '0 && !s.ctrl[BIT_NULL_VID]
      |=> dec_lookup_vid == $past(port_default_vlan))
      else $error("null VID did not use default");
   a_ingress_filter: assert property (
      rx_valid && s.ctrl[BIT_INGRESS_FILT] && !rx_vlan_member |=> dec_valid && dec_drop)
      else $error("non-member frame kept");
   a_nondefault_drop: assert property (
      rx_valid && s.ctrl[BIT_DISCARD_NONDEF] && rx_tagged && rx_vid != '0
      && rx_vid != port_default_vlan |=> dec_drop)
      else $error("non-default VID frame kept");
   a_self_addr_drop: assert property (
      rx_valid && s.ctrl[BIT_SELF_FILT] && self_filter_global_en
      && rx_src_mac == switch_mac |=> dec_drop)
      else $error("self address frame kept");
   a_self_addr_gate: assert property (
      rx_valid && !self_filter_global_en && !s.ctrl[BIT_INGRESS_FILT]
      && !s.ctrl[BIT_DISCARD_NONDEF] && rx_enable_map[rx_instance] |=> !dec_drop)
      else $error("frame dropped without enabled cause");
   a_state_indexed: assert property (
      reg_wr && reg_addr == {PORT_NUM, OFF_INST_STATE}
      |=> tx_enable_map[$past(sel)] == $past(reg_wdata[2])
      && learn_disable_map[$past(sel)] == $past(reg_wdata[0]))
      else $error("instance state write missed entry");
   a_rx_latency: assert property (
      rx_ts_valid |=> rx_ts_out_valid && rx_ts_wire == $past(rx_ts_raw) - $past(s.rx_lat))
      else $error("receive latency not applied");
   a_tx_latency: assert property (
      tx_ts_valid |=> tx_ts_wire == $past(tx_ts_raw) + $past(s.tx_lat))
      else $error("transmit latency not applied");
   a_skew_ingress: assert property (
      corr_valid && !corr_egress && corr_msg_type == PLC_MSG_SYNC
      |=> corr_out == $past(corr_in) + $past(skew_scaled))
      else $error("ingress skew not added");
   a_skew_egress: assert property (
      corr_valid && corr_egress && corr_msg_type == PLC_MSG_PDELAY_REQ
      |=> corr_out == $past(corr_in) - $past(skew_scaled))
      else $error("egress skew not subtracted");

   // Sign and magnitude are checked apart from the scaled value the datapath builds
   a_skew_neg_ingress: assert property (
      corr_valid && !corr_egress && s.skew[BIT_SKEW_SIGN]
      && (corr_msg_type == PLC_MSG_SYNC || corr_msg_type == PLC_MSG_PDELAY_RESP)
      |=> corr_out + {33'h0_0000_0000, $past(s.skew[14:0]), 16'h0000} == $past(corr_in))
      else $error("negative skew not applied on ingress");
   a_skew_pos_egress: assert property (
      corr_valid && corr_egress && !s.skew[BIT_SKEW_SIGN]
      && (corr_msg_type == PLC_MSG_DELAY_REQ || corr_msg_type == PLC_MSG_PDELAY_REQ)
      |=> corr_out + {33'h0_0000_0000, $past(s.skew[14:0]), 16'h0000} == $past(corr_in))
      else $error("positive skew not applied on egress");
   a_skew_passthru: assert property (
      corr_valid && corr_egress && corr_msg_type == PLC_MSG_SYNC |=> corr_out == $past(corr_in))
      else $error("egress Sync correction changed");
   a_corr_follow: assert property (
      corr_valid |=> corr_out_valid)
      else $error("correction result missing");

   // Reset values must already show on the first cycle after release
   a_reset_state: assert property (
      !$past(resetn) |-> tx_enable_map == '1 && rx_enable_map == '1
      && learn_disable_map == '0 && s.rx_lat == RST_RX_LAT && s.tx_lat == RST_TX_LAT)
      else $error("reset state not restored");
   a_mac_8021x_bit: assert property (
      reg_wr && reg_addr == {PORT_NUM, OFF_LOOKUP_CTRL}
      |=> mac_8021x_en == $past(reg_wdata[BIT_MAC_8021X]))
      else $error("802.1X enable not taken from write");
   a_rx_enable_write: assert property (
      reg_wr && reg_addr == {PORT_NUM, OFF_INST_STATE}
      |=> rx_enable_map[$past(sel)] == $past(reg_wdata[BIT_RX_EN]))
      else $error("receive enable write missed entry");
   a_state_read: assert property (
      reg_rd && reg_addr == {PORT_NUM, OFF_INST_STATE} |=> reg_rdata_valid
      && reg_rdata == {5'h00, $past(tx_enable_map[sel]), $past(rx_enable_map[sel]),
      $past(learn_disable_map[sel])})
      else $error("instance state read missed entry");
   a_rx_blocked: assert property (
      rx_valid && !rx_enable_map[rx_instance] |=> dec_drop)
      else $error("frame kept on blocked instance");
   a_learn_follow: assert property (
      rx_valid |=> dec_learn == !$past(learn_disable_map[rx_instance]))
      else $error("learning does not follow instance state");
   a_no_cause_kept: assert property (
      rx_valid && s.ctrl[BIT_INGRESS_FILT] && s.ctrl[BIT_DISCARD_NONDEF] && rx_vlan_member
      && rx_tagged && rx_vid == port_default_vlan && rx_src_mac != switch_mac
      && rx_enable_map[rx_instance] |=> dec_valid && !dec_drop)
      else $error("frame dropped with no cause met");
   a_ts_idle: assert property (
      !rx_ts_valid && !tx_ts_valid |=> !rx_ts_out_valid && !tx_ts_out_valid)
      else $error("timestamp output without request");

   c_self_drop: cover property (rx_valid && self_drop ##1 dec_drop);
   c_null_vid: cover property (rx_valid && rx_tagged && rx_vid == '0 && s.ctrl[BIT_NULL_VID]);
   c_neg_skew: cover property (corr_valid && corr_egress && s.skew[BIT_SKEW_SIGN]);
   c_state_read: cover property (
      reg_rd && reg_addr == {PORT_NUM, OFF_INST_STATE} ##1 reg_rdata_valid);
   c_rx_blocked: cover property (rx_valid && !rx_enable_map[rx_instance] ##1 dec_drop);

endmodule : plc_port_bank

// *** tb/plc_port_bank_tb_top.sv ***
// Self-checking bench for the per-port lookup and PTP configuration bank
`timescale 1ns/1ps
module plc_port_bank_tb_top;
   import plc_pkg::*;
   // ==========================================================
   // Signals
   logic clk, resetn, reg_wr, reg_rd, reg_rdata_valid, rx_valid, rx_tagged, rx_vlan_member;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, tx_enable_map, rx_enable_map, learn_disable_map;
   logic [11:0] rx_vid, port_default_vlan, dec_lookup_vid;
   logic [2:0] rx_instance;
   logic [47:0] rx_src_mac, switch_mac;
   logic self_filter_global_en, dec_valid, dec_drop, dec_learn, mac_8021x_en;
   logic rx_ts_valid, tx_ts_valid, rx_ts_out_valid, tx_ts_out_valid;
   logic [31:0] rx_ts_raw, tx_ts_raw, rx_ts_wire, tx_ts_wire;
   logic corr_valid, corr_egress, corr_out_valid;
   logic [3:0] corr_msg_type;
   logic [63:0] corr_in, corr_out;
   int num_errors = 0;
   int check_count = 0;
   localparam logic [47:0] MAC = 48'h0200_0000_0001;
   localparam logic [63:0] CIN = 64'h0000_0000_0010_0000;
   plc_port_bank DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rdata_valid(reg_rdata_valid), .rx_valid(rx_valid), .rx_tagged(rx_tagged),
      .rx_vid(rx_vid), .port_default_vlan(port_default_vlan), .rx_vlan_member(rx_vlan_member),
      .rx_instance(rx_instance), .rx_src_mac(rx_src_mac), .switch_mac(switch_mac),
      .self_filter_global_en(self_filter_global_en), .dec_valid(dec_valid),
      .dec_lookup_vid(dec_lookup_vid), .dec_drop(dec_drop), .dec_learn(dec_learn),
      .mac_8021x_en(mac_8021x_en), .tx_enable_map(tx_enable_map),
      .rx_enable_map(rx_enable_map), .learn_disable_map(learn_disable_map),
      .rx_ts_valid(rx_ts_valid), .rx_ts_raw(rx_ts_raw), .tx_ts_valid(tx_ts_valid),
      .tx_ts_raw(tx_ts_raw), .rx_ts_out_valid(rx_ts_out_valid), .rx_ts_wire(rx_ts_wire),
      .tx_ts_out_valid(tx_ts_out_valid), .tx_ts_wire(tx_ts_wire), .corr_valid(corr_valid),
      .corr_egress(corr_egress), .corr_msg_type(corr_msg_type), .corr_in(corr_in),
      .corr_out_valid(corr_out_valid), .corr_out(corr_out));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ==========================================================
   // Tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [11:0] o, input logic [7:0] d, input logic [3:0] p = 4'h1);
      @(negedge clk);
      reg_addr = {p, o};
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] o, input logic [7:0] e);
      @(negedge clk);
      reg_addr = {4'h1, o};
      reg_rd = 1'b1;
      @(posedge clk);
      @(negedge clk);
      reg_rd = 1'b0;
      chk("rdata_valid", 64'h1, {63'h0, reg_rdata_valid});
      chk("rdata", {56'h0, e}, {56'h0, reg_rdata});
   endtask : rd
   task automatic frm(input logic tg, input logic [11:0] v, input logic m, input logic [2:0] i,
         input logic [47:0] s, input logic [11:0] ev, input logic ed, input logic el);
      @(negedge clk);
      {rx_tagged, rx_vid, rx_vlan_member, rx_instance, rx_src_mac} = {tg, v, m, i, s};
      rx_valid = 1'b1;
      @(posedge clk);
      @(negedge clk);
      rx_valid = 1'b0;
      chk("dec_valid", 64'h1, {63'h0, dec_valid});
      chk("dec_lookup_vid", {52'h0, ev}, {52'h0, dec_lookup_vid});
      chk("dec_drop", {63'h0, ed}, {63'h0, dec_drop});
      chk("dec_learn", {63'h0, el}, {63'h0, dec_learn});
   endtask : frm
   task automatic ts(input logic [31:0] raw, input logic [31:0] er, input logic [31:0] et);
      @(negedge clk);
      {rx_ts_raw, tx_ts_raw, rx_ts_valid, tx_ts_valid} = {raw, raw, 2'b11};
      @(posedge clk);
      @(negedge clk);
      {rx_ts_valid, tx_ts_valid} = 2'b00;
      chk("ts_valids", 64'h3, {62'h0, rx_ts_out_valid, tx_ts_out_valid});
      chk("rx_ts_wire", {32'h0, er}, {32'h0, rx_ts_wire});
      chk("tx_ts_wire", {32'h0, et}, {32'h0, tx_ts_wire});
   endtask : ts
   task automatic cr(input logic eg, input logic [3:0] t, input logic [63:0] e);
      @(negedge clk);
      {corr_egress, corr_msg_type, corr_in, corr_valid} = {eg, t, CIN, 1'b1};
      @(posedge clk);
      @(negedge clk);
      corr_valid = 1'b0;
      chk("corr_out_valid", 64'h1, {63'h0, corr_out_valid});
      chk("corr_out", e, corr_out);
   endtask : cr
   // ==========================================================
   // Watchdog, far beyond the couple of hundred cycles the tests take
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end
   // ==========================================================
   // Tests
   initial begin
      {resetn, reg_wr, reg_rd, rx_valid, rx_ts_valid, tx_ts_valid, corr_valid} = 7'h00;
      {reg_addr, reg_wdata, rx_tagged, rx_vid, rx_vlan_member, rx_instance} = '0;
      {rx_src_mac, rx_ts_raw, tx_ts_raw, corr_egress, corr_msg_type, corr_in} = '0;
      port_default_vlan = 12'h010;
      switch_mac = MAC;
      self_filter_global_en = 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      rd(OFF_LOOKUP_CTRL, 8'h00);
      rd(OFF_INST_PTR, 8'h00);
      rd(OFF_INST_STATE, 8'h06);
      rd(OFF_RX_LAT, 8'h01);
      rd(OFF_RX_LAT + 12'h001, 8'h9f);
      rd(OFF_TX_LAT, 8'h00);
      rd(OFF_TX_LAT + 12'h001, 8'h2d);
      rd(OFF_SKEW, 8'h00);
      rd(OFF_SKEW + 12'h001, 8'h00);
      chk("maps", 64'hff_ff00, {40'h0, tx_enable_map, rx_enable_map, learn_disable_map});
      ts(32'd1000, 32'd585, 32'd1045);
      $display("test reset_values done");
      wr(OFF_LOOKUP_CTRL, 8'hff);
      rd(OFF_LOOKUP_CTRL, 8'hfa);
      chk("mac_8021x_en", 64'h1, {63'h0, mac_8021x_en});
      wr(OFF_LOOKUP_CTRL, 8'h00);
      chk("mac_8021x_en", 64'h0, {63'h0, mac_8021x_en});
      wr(OFF_LOOKUP_CTRL, 8'hff, 4'h2);
      rd(OFF_LOOKUP_CTRL, 8'h00);
      rd(12'hb02, 8'h00);
      $display("test control_access done");
      for (int i = 0; i < 8; i++) begin
         wr(OFF_INST_PTR, 8'(i));
         wr(OFF_INST_STATE, {5'h1f, 3'(i)});
      end
      for (int i = 0; i < 8; i++) begin
         wr(OFF_INST_PTR, 8'(i));
         rd(OFF_INST_STATE, 8'(i));
      end
      chk("maps", 64'hf0_ccaa, {40'h0, tx_enable_map, rx_enable_map, learn_disable_map});
      $display("test instance_state done");
      frm(1, 12'h000, 1, 3'd2, 48'h0, 12'h010, 0, 1);
      frm(1, 12'h000, 1, 3'd1, 48'h0, 12'h010, 1, 0);
      frm(1, 12'h123, 1, 3'd3, 48'h0, 12'h123, 0, 0);
      wr(OFF_LOOKUP_CTRL, 8'h80);
      frm(1, 12'h000, 1, 3'd2, 48'h0, 12'h000, 0, 1);
      frm(1, 12'h005, 0, 3'd2, 48'h0, 12'h005, 0, 1);
      wr(OFF_LOOKUP_CTRL, 8'h40);
      frm(1, 12'h005, 0, 3'd2, 48'h0, 12'h005, 1, 1);
      frm(1, 12'h005, 1, 3'd2, 48'h0, 12'h005, 0, 1);
      wr(OFF_LOOKUP_CTRL, 8'h20);
      frm(1, 12'h005, 1, 3'd2, 48'h0, 12'h005, 1, 1);
      frm(0, 12'h005, 1, 3'd2, 48'h0, 12'h010, 0, 1);
      frm(1, 12'h010, 1, 3'd2, MAC, 12'h010, 0, 1);
      wr(OFF_LOOKUP_CTRL, 8'h08);
      frm(1, 12'h010, 1, 3'd2, MAC, 12'h010, 0, 1);
      @(negedge clk);
      self_filter_global_en = 1'b1;
      frm(1, 12'h010, 1, 3'd2, MAC, 12'h010, 1, 1);
      frm(1, 12'h010, 1, 3'd2, MAC + 48'h1, 12'h010, 0, 1);
      wr(OFF_LOOKUP_CTRL, 8'h68);
      frm(1, 12'h010, 1, 3'd2, 48'h0, 12'h010, 0, 1);
      frm(1, 12'h010, 0, 3'd2, 48'h0, 12'h010, 1, 1);
      frm(1, 12'h011, 1, 3'd2, 48'h0, 12'h011, 1, 1);
      $display("test frame_decision done");
      wr(OFF_RX_LAT, 8'h00);
      wr(OFF_RX_LAT + 12'h001, 8'h10);
      wr(OFF_TX_LAT, 8'h01);
      wr(OFF_TX_LAT + 12'h001, 8'h00);
      ts(32'd1000, 32'd984, 32'd1256);
      ts(32'd5, 32'hffff_fff5, 32'd261);
      $display("test latency done");
      wr(OFF_SKEW, 8'h80);
      wr(OFF_SKEW + 12'h001, 8'h03);
      cr(0, PLC_MSG_SYNC, CIN - 64'h3_0000);
      cr(1, PLC_MSG_DELAY_REQ, CIN + 64'h3_0000);
      cr(0, PLC_MSG_DELAY_REQ, CIN);
      wr(OFF_SKEW, 8'h00);
      wr(OFF_SKEW + 12'h001, 8'h05);
      cr(0, PLC_MSG_PDELAY_RESP, CIN + 64'h5_0000);
      cr(1, PLC_MSG_PDELAY_REQ, CIN - 64'h5_0000);
      cr(1, PLC_MSG_SYNC, CIN);
      $display("test skew_correction done");
      @(negedge clk);
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      rd(OFF_LOOKUP_CTRL, 8'h00);
      rd(OFF_INST_STATE, 8'h06);
      rd(OFF_SKEW + 12'h001, 8'h00);
      chk("maps", 64'hff_ff00, {40'h0, tx_enable_map, rx_enable_map, learn_disable_map});
      $display("test mid_reset done");
      stop_test();
   end
endmodule : plc_port_bank_tb_top
